/* shared/lane_pkg.sv */
package lane_pkg;
   // Lane word and delay geometry.
   localparam int          BYTE_W    = 8;
   localparam int          TAP_W     = 3;
   localparam logic [2:0]  LAST_BIT  = 3'h7;
   localparam logic [2:0]  HALF_BIT  = 3'h3;
   localparam logic [2:0]  TAP_INIT  = 3'h0;
   localparam logic [2:0]  TAP_MAX   = 3'h7;
   localparam logic [2:0]  TAP_MIN   = 3'h0;

   // Controller register byte addresses.
   localparam logic [11:0] CTRL_OFS  = 12'h000;
   localparam logic [11:0] TXD_OFS   = 12'h004;
   localparam logic [11:0] DLY_OFS   = 12'h008;
   localparam logic [11:0] STAT_OFS  = 12'h00C;
   localparam logic [11:0] RXD_OFS   = 12'h010;

   // Control register fields.
   localparam int CTL_BUF    = 0;
   localparam int CTL_TERM   = 1;
   localparam int CTL_TX_FAST_DRIVE_ON  = 2;
   localparam int CTL_POS_OE = 3;
   localparam int CTL_NEG_OE = 4;
   localparam int CTL_POS    = 5;
   localparam int CTL_NEG    = 6;
   localparam int CTL_RX_RST = 7;
   localparam int CTL_TX_RST = 8;
   localparam int CTL_W      = 9;
   localparam logic [8:0] CTL_RESET = 9'h180;

   // Delay register fields.
   localparam int DLY_STEP  = 0;
   localparam int DLY_UP    = 1;
   localparam int DLY_CLR   = 2;

   // Status and receive-data fields.
   localparam int STAT_POS   = 0;
   localparam int STAT_NEG   = 1;
   localparam int STAT_EMPTY = 2;
   localparam int STAT_TAP   = 4;
   localparam int RXD_VALID  = 31;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* shared/lane_if.sv */
interface lane_if;
   // Receive path towards the core.
   logic [lane_pkg::BYTE_W-1:0] rx_fast_byte;
   logic                        byte_tick;
   logic                        lowpwr_pos_sense;
   logic                        lowpwr_neg_sense;
   logic                        queue_empty;
   logic                        queue_read_en;
   logic                        rx_reset;
   logic                        rx_diff_buffer_on;
   logic                        rx_termination_on;
   // Forwarded clocks.
   logic                        lane_parallel_clk_fwd;
   logic                        lane_serial_clk_fwd;
   logic                        lane_core_clk;
   // Delay control.
   logic                        delay_step_enable;
   logic                        delay_step_up;
   logic                        delay_counter_clear;
   logic [lane_pkg::TAP_W-1:0]  delay_tap;
   // Transmit path from the core.
   logic [lane_pkg::BYTE_W-1:0] tx_fast_byte;
   logic                        tx_fast_drive_on;
   logic                        tx_reset;
   logic                        lowpwr_pos_drive;
   logic                        lowpwr_neg_drive;
   logic                        lowpwr_pos_drive_on;
   logic                        lowpwr_neg_drive_on;

   modport lane (
      output rx_fast_byte, byte_tick, lowpwr_pos_sense, lowpwr_neg_sense, queue_empty,
      output lane_parallel_clk_fwd, lane_serial_clk_fwd, lane_core_clk, delay_tap,
      input  queue_read_en, rx_reset, rx_diff_buffer_on, rx_termination_on,
      input  delay_step_enable, delay_step_up, delay_counter_clear,
      input  tx_fast_byte, tx_fast_drive_on, tx_reset, lowpwr_pos_drive, lowpwr_neg_drive,
      input  lowpwr_pos_drive_on, lowpwr_neg_drive_on
   );
   modport ctrl (
      input  rx_fast_byte, byte_tick, lowpwr_pos_sense, lowpwr_neg_sense, queue_empty,
      input  lane_parallel_clk_fwd, lane_serial_clk_fwd, lane_core_clk, delay_tap,
      output queue_read_en, rx_reset, rx_diff_buffer_on, rx_termination_on,
      output delay_step_enable, delay_step_up, delay_counter_clear,
      output tx_fast_byte, tx_fast_drive_on, tx_reset, lowpwr_pos_drive, lowpwr_neg_drive,
      output lowpwr_pos_drive_on, lowpwr_neg_drive_on
   );
endinterface

/* core/serial_lane.sv */
module serial_lane #(
   parameter bit QUEUE_EN    = 1'b1,
   parameter int QUEUE_DEPTH = 4
) (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Core side.
   lane_if.lane      lnk,
   // Pad side.
   input  wire logic pad_p_in,
   input  wire logic pad_n_in,
   output logic      pad_p_out,
   output logic      pad_p_oe,
   output logic      pad_n_out,
   output logic      pad_n_oe,
   output logic      term_on
);
   localparam int AW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
   localparam int B  = lane_pkg::BYTE_W;

   generate
      if (QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_chk
         $error("QUEUE_DEPTH must be a power of two of at least 2.");
      end
   endgenerate

   // Saturating tap step; each limit is checked in its own branch.
   function automatic logic [lane_pkg::TAP_W-1:0] tap_step(input logic [lane_pkg::TAP_W-1:0] t,
                                                           input logic up);
      if (up) begin
         tap_step = (t == lane_pkg::TAP_MAX) ? t : t + 1'b1;
      end else begin
         tap_step = (t == lane_pkg::TAP_MIN) ? t : t - 1'b1;
      end
   endfunction

   logic [1:0]       p_sync_q;
   logic [1:0]       n_sync_q;
   logic [B-1:0]     hist_q;
   logic [2:0]       bit_cnt_q;
   logic [B-1:0]     rx_shift_q;
   logic [B-1:0]     rx_byte_q;
   logic             tick_q;
   logic [2:0]       tap_q;
   logic             ser_clk_q;
   logic             par_clk_q;
   logic [B-1:0]     tx_shift_q;
   logic             p_out_d;
   logic             n_out_d;
   logic [B-1:0]     mem [QUEUE_DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             rx_bit;
   logic             last_bit;
   logic             push;
   logic             pop;
   logic             q_empty;
   logic             q_full;

   // Pad levels are foreign to aclk, so two flip-flops come before any use.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p_sync_q <= 2'h0;
         n_sync_q <= 2'h0;
      end else begin
         p_sync_q <= {p_sync_q[0], pad_p_in};
         n_sync_q <= {n_sync_q[0], pad_n_in};
      end
   end

   // Low-power sense levels go out undecoded, one per pad.
   assign lnk.lowpwr_pos_sense = p_sync_q[1];
   assign lnk.lowpwr_neg_sense = n_sync_q[1];

   // Bit counter divides the serial rate by eight to make the parallel rate.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt_q <= 3'h0;
         ser_clk_q <= 1'b0;
         par_clk_q <= 1'b0;
         tick_q    <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         ser_clk_q <= ~ser_clk_q;
         par_clk_q <= (bit_cnt_q >= lane_pkg::HALF_BIT) && (bit_cnt_q != lane_pkg::LAST_BIT);
         tick_q    <= (bit_cnt_q == lane_pkg::LAST_BIT);
      end
   end

   assign last_bit                  = (bit_cnt_q == lane_pkg::LAST_BIT);
   assign lnk.lane_serial_clk_fwd   = ser_clk_q;
   assign lnk.lane_parallel_clk_fwd = par_clk_q;
   assign lnk.lane_core_clk         = par_clk_q;
   assign lnk.byte_tick             = tick_q;

   // Delay line: a history of pad samples, the tap picks how late to look.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hist_q <= '0;
      end else begin
         hist_q <= {hist_q[B-2:0], p_sync_q[1]};
      end
   end

   assign rx_bit = hist_q[tap_q];

   // Tap moves only on a slow-clock edge, and clear outranks a step.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tap_q <= lane_pkg::TAP_INIT;
      end else if (tick_q && lnk.delay_counter_clear) begin
         tap_q <= lane_pkg::TAP_INIT;
      end else if (tick_q && lnk.delay_step_enable) begin
         tap_q <= tap_step(tap_q, lnk.delay_step_up);
      end
   end

   assign lnk.delay_tap = tap_q;

   // Deserializer, most significant bit first; the buffer must be on.
   always_ff @(posedge aclk) begin
      if (!aresetn || lnk.rx_reset) begin
         rx_shift_q <= '0;
         rx_byte_q  <= '0;
      end else if (lnk.rx_diff_buffer_on) begin
         rx_shift_q <= {rx_shift_q[B-2:0], rx_bit};
         if (last_bit) begin
            rx_byte_q <= {rx_shift_q[B-2:0], rx_bit};
         end
      end
   end

   // Termination follows the core's level; it has no other effect here.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         term_on <= 1'b0;
      end else begin
         term_on <= lnk.rx_termination_on;
      end
   end

   // Queue: a full queue drops the new byte rather than stalling the wire.
   assign q_empty = (wr_ptr_q == rd_ptr_q);
   assign q_full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign push    = QUEUE_EN && last_bit && lnk.rx_diff_buffer_on && !q_full && !lnk.rx_reset;
   assign pop     = QUEUE_EN && lnk.queue_read_en && !q_empty;

   always_ff @(posedge aclk) begin
      if (!aresetn || lnk.rx_reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_q[AW-1:0]] <= {rx_shift_q[B-2:0], rx_bit};
      end
   end

   // With the queue the head is shown; without it the last whole byte.
   assign lnk.rx_fast_byte = QUEUE_EN ? mem[rd_ptr_q[AW-1:0]] : rx_byte_q;
   assign lnk.queue_empty  = QUEUE_EN ? q_empty : 1'b0;

   // Serializer loads a new byte each parallel period.
   always_ff @(posedge aclk) begin
      if (!aresetn || lnk.tx_reset) begin
         tx_shift_q <= '0;
      end else if (last_bit) begin
         tx_shift_q <= lnk.tx_fast_byte;
      end else begin
         tx_shift_q <= {tx_shift_q[B-2:0], 1'b0};
      end
   end

   // High-speed drive wins over low-power drive on the pads.
   always_comb begin
      if (lnk.tx_fast_drive_on) begin
         p_out_d = tx_shift_q[B-1];
         n_out_d = ~tx_shift_q[B-1];
      end else begin
         p_out_d = lnk.lowpwr_pos_drive;
         n_out_d = lnk.lowpwr_neg_drive;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_p_out <= 1'b0;
         pad_n_out <= 1'b0;
         pad_p_oe  <= 1'b0;
         pad_n_oe  <= 1'b0;
      end else begin
         pad_p_out <= p_out_d;
         pad_n_out <= n_out_d;
         pad_p_oe  <= lnk.tx_fast_drive_on | lnk.lowpwr_pos_drive_on;
         pad_n_oe  <= lnk.tx_fast_drive_on | lnk.lowpwr_neg_drive_on;
      end
   end
endmodule

/* core/lane_controller.sv */
module lane_controller (
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Lane side.
   lane_if.ctrl             lnk,
   // AXI4-Lite write.
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read.
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   logic [11:0]                 aw_q;
   logic                        aw_have_q;
   logic [31:0]                 w_q;
   logic                        w_have_q;
   logic [3:0]                  wstrb_q;
   logic [lane_pkg::CTL_W-1:0]  ctl_q;
   logic [lane_pkg::BYTE_W-1:0] txd_q;
   logic                        step_q;
   logic                        up_q;
   logic                        clr_q;
   logic                        pop_q;
   logic [1:0]                  pos_sync_q;
   logic [1:0]                  neg_sync_q;
   logic                        do_wr;
   logic                        ar_hs;

   assign do_wr = aw_have_q && w_have_q && !bvalid;
   assign ar_hs = arvalid && arready;

   // Address and data are caught in either order, one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_q      <= '0;
         w_q       <= '0;
         wstrb_q   <= '0;
         bvalid    <= 1'b0;
         bresp     <= lane_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_q      <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_q      <= wdata;
            wstrb_q  <= wstrb;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= (aw_q == lane_pkg::CTRL_OFS || aw_q == lane_pkg::TXD_OFS ||
                          aw_q == lane_pkg::DLY_OFS) ? lane_pkg::RESP_OKAY : lane_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   assign awready = !aw_have_q && !bvalid;
   assign wready  = !w_have_q && !bvalid;

   // Control and transmit byte registers; the strobes are kept with the data, since the bus may move them.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= lane_pkg::CTL_RESET;
         txd_q <= '0;
      end else if (do_wr) begin
         if (aw_q == lane_pkg::CTRL_OFS && wstrb_q[0]) begin
            ctl_q[7:0] <= w_q[7:0];
         end
         if (aw_q == lane_pkg::CTRL_OFS && wstrb_q[1]) begin
            ctl_q[8] <= w_q[8];
         end
         if (aw_q == lane_pkg::TXD_OFS && wstrb_q[0]) begin
            txd_q <= w_q[7:0];
         end
      end
   end

   // A delay command waits for the next parallel tick; a new write wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_q <= 1'b0;
         up_q   <= 1'b0;
         clr_q  <= 1'b0;
      end else if (do_wr && aw_q == lane_pkg::DLY_OFS && wstrb_q[0]) begin
         step_q <= w_q[lane_pkg::DLY_STEP];
         up_q   <= w_q[lane_pkg::DLY_UP];
         clr_q  <= w_q[lane_pkg::DLY_CLR];
      end else if (lnk.byte_tick) begin
         step_q <= 1'b0;
         clr_q  <= 1'b0;
      end
   end

   // Sense levels already leave the lane on aclk flip-flops, and are synchronised here again.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_sync_q <= 2'h0;
         neg_sync_q <= 2'h0;
      end else begin
         pos_sync_q <= {pos_sync_q[0], lnk.lowpwr_pos_sense};
         neg_sync_q <= {neg_sync_q[0], lnk.lowpwr_neg_sense};
      end
   end

   // Reads answer one cycle after the address; reading data pops the queue.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= lane_pkg::RESP_OKAY;
         pop_q  <= 1'b0;
      end else begin
         pop_q <= 1'b0;
         if (ar_hs) begin
            rvalid <= 1'b1;
            rresp  <= lane_pkg::RESP_OKAY;
            rdata  <= '0;
            unique case (araddr)
               lane_pkg::CTRL_OFS: rdata[lane_pkg::CTL_W-1:0] <= ctl_q;
               lane_pkg::TXD_OFS:  rdata[7:0] <= txd_q;
               lane_pkg::DLY_OFS:  rdata[2:0] <= {clr_q, up_q, step_q};
               lane_pkg::STAT_OFS: begin
                  rdata[lane_pkg::STAT_POS]        <= pos_sync_q[1];
                  rdata[lane_pkg::STAT_NEG]        <= neg_sync_q[1];
                  rdata[lane_pkg::STAT_EMPTY]      <= lnk.queue_empty;
                  rdata[lane_pkg::STAT_TAP +: 3]   <= lnk.delay_tap;
               end
               lane_pkg::RXD_OFS: begin
                  // An empty queue reads as zero, so stale words never leak out.
                  if (!lnk.queue_empty) begin
                     rdata[7:0]                 <= lnk.rx_fast_byte;
                     rdata[lane_pkg::RXD_VALID] <= 1'b1;
                     pop_q                      <= 1'b1;
                  end
               end
               default: rresp <= lane_pkg::RESP_SLVERR;
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   assign arready = !rvalid && !pop_q;

   // Lane controls straight from registers.
   assign lnk.rx_diff_buffer_on   = ctl_q[lane_pkg::CTL_BUF];
   assign lnk.rx_termination_on   = ctl_q[lane_pkg::CTL_TERM];
   assign lnk.tx_fast_drive_on    = ctl_q[lane_pkg::CTL_TX_FAST_DRIVE_ON];
   assign lnk.lowpwr_pos_drive_on = ctl_q[lane_pkg::CTL_POS_OE];
   assign lnk.lowpwr_neg_drive_on = ctl_q[lane_pkg::CTL_NEG_OE];
   assign lnk.lowpwr_pos_drive    = ctl_q[lane_pkg::CTL_POS];
   assign lnk.lowpwr_neg_drive    = ctl_q[lane_pkg::CTL_NEG];
   assign lnk.rx_reset            = ctl_q[lane_pkg::CTL_RX_RST];
   assign lnk.tx_reset            = ctl_q[lane_pkg::CTL_TX_RST];
   assign lnk.tx_fast_byte        = txd_q;
   assign lnk.delay_step_enable   = step_q;
   assign lnk.delay_step_up       = up_q;
   assign lnk.delay_counter_clear = clr_q;
   assign lnk.queue_read_en       = pop_q;
endmodule

/* sim/lane_chk.sv */
module lane_chk (
   // Clock and reset.
   input wire logic                        aclk,
   input wire logic                        aresetn,
   // Receive path and queue, and the transmit reset.
   input wire logic [lane_pkg::BYTE_W-1:0] rx_fast_byte,
   input wire logic                        byte_tick,
   input wire logic                        queue_empty,
   input wire logic                        queue_read_en,
   input wire logic                        rx_reset,
   input wire logic                        tx_reset,
   // Forwarded clocks.
   input wire logic                        lane_parallel_clk_fwd,
   input wire logic                        lane_serial_clk_fwd,
   input wire logic                        lane_core_clk,
   // Delay control.
   input wire logic                        delay_step_enable,
   input wire logic                        delay_step_up,
   input wire logic                        delay_counter_clear,
   input wire logic [lane_pkg::TAP_W-1:0]  delay_tap
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A step command only counts at a byte boundary, and a clear always beats it.
   sequence tap_cmd;
      byte_tick && delay_step_enable && !delay_counter_clear && !rx_reset;
   endsequence
   sequence tick_gap;
      !byte_tick [*7];
   endsequence

   // Byte boundaries are exactly eight cycles apart while no reset intervenes.
   tick_gap_a: assert property (byte_tick |=> tick_gap)
      else $error("byte tick arrived early");
   tick_period_a: assert property (byte_tick ##1 !(rx_reset || tx_reset) [*8] |-> byte_tick)
      else $error("byte tick missing after eight cycles");
   clk_tie_a: assert property (lane_parallel_clk_fwd == lane_core_clk)
      else $error("core clock differs from parallel clock");
   ser_toggle_a: assert property ($past(aresetn) |-> lane_serial_clk_fwd != $past(lane_serial_clk_fwd))
      else $error("serial clock did not toggle");
   par_rise_a: assert property (byte_tick |-> ##4 $rose(lane_parallel_clk_fwd))
      else $error("parallel clock rise not four cycles after byte tick");
   tap_up_a: assert property ((tap_cmd ##0 (delay_step_up && delay_tap != lane_pkg::TAP_MAX))
      |=> delay_tap == $past(delay_tap) + 3'h1)
      else $error("tap did not step up");
   tap_down_a: assert property ((tap_cmd ##0 (!delay_step_up && delay_tap != lane_pkg::TAP_MIN))
      |=> delay_tap == $past(delay_tap) - 3'h1)
      else $error("tap did not step down");
   tap_clear_a: assert property (byte_tick && delay_counter_clear |=> delay_tap == lane_pkg::TAP_INIT)
      else $error("tap not returned to initial setting");
   tap_hold_a: assert property (!byte_tick && !rx_reset |=> $stable(delay_tap))
      else $error("tap moved between byte boundaries");
   cmd_hold_a: assert property (delay_step_enable && !byte_tick |=> delay_step_enable)
      else $error("step command dropped before byte boundary");
   empty_reset_a: assert property (rx_reset |=> queue_empty)
      else $error("queue not empty after receive reset");
   pop_pulse_a: assert property (queue_read_en |=> !queue_read_en)
      else $error("pop longer than one cycle");
   head_hold_a: assert property (!queue_empty && !queue_read_en && !rx_reset |=> $stable(rx_fast_byte))
      else $error("queue head changed without pop");
endmodule

/* sim/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, p_drv, n_drv;
   logic        pad_p_out, pad_p_oe, pad_n_out, pad_n_oe, term_on;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [2:0]  exp_tap;
   int          n_mismatch, samples_checked;

   lane_if lnk_bus ();

   // Pads loop back while the lane drives them; otherwise the bench sets the level.
   wire pad_p_in = pad_p_oe ? pad_p_out : p_drv;
   wire pad_n_in = pad_n_oe ? pad_n_out : n_drv;

   serial_lane serial_lane_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk_bus.lane), .pad_p_in(pad_p_in),
      .pad_n_in(pad_n_in), .pad_p_out(pad_p_out), .pad_p_oe(pad_p_oe), .pad_n_out(pad_n_out),
      .pad_n_oe(pad_n_oe), .term_on(term_on));
   lane_controller lane_controller_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk_bus.ctrl),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   lane_chk lane_chk_inst (.aclk(aclk), .aresetn(aresetn), .rx_fast_byte(lnk_bus.rx_fast_byte),
      .byte_tick(lnk_bus.byte_tick), .queue_empty(lnk_bus.queue_empty), .queue_read_en(lnk_bus.queue_read_en),
      .rx_reset(lnk_bus.rx_reset), .tx_reset(lnk_bus.tx_reset), .lane_parallel_clk_fwd(lnk_bus.lane_parallel_clk_fwd),
      .lane_core_clk(lnk_bus.lane_core_clk), .delay_step_enable(lnk_bus.delay_step_enable),
      .delay_step_up(lnk_bus.delay_step_up), .delay_counter_clear(lnk_bus.delay_counter_clear),
      .delay_tap(lnk_bus.delay_tap), .lane_serial_clk_fwd(lnk_bus.lane_serial_clk_fwd));

   // The clock runs at 25 MHz.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic complete_run();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   // True when b is some rotation of p, so framing latency does not matter but bit order does.
   function automatic bit is_rot(input logic [7:0] b, input logic [7:0] p);
      logic [15:0] t;
      for (int i = 0; i < 8; i++) begin
         t = {p, p} >> i;
         if (t[7:0] === b) return 1'b1;
      end
      return 1'b0;
   endfunction

   // Address and data are offered together and each released when taken.
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic t_reset();
      axi_rd(lane_pkg::CTRL_OFS, lane_pkg::RESP_OKAY);
      chk("ctrl reset", 32'h0000_0180, rd);
      axi_rd(lane_pkg::STAT_OFS, lane_pkg::RESP_OKAY);
      chk("stat reset", 32'h0000_0004, rd);
      axi_rd(12'h020, lane_pkg::RESP_SLVERR);
      chk("unmapped read", 32'h0000_0000, rd);
      axi_wr(lane_pkg::STAT_OFS, 32'h0000_0003, lane_pkg::RESP_SLVERR);
   endtask

   // Low-power drive and sense, looped through the pads and then from the bench.
   task automatic t_lowpwr();
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0038, lane_pkg::RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("pad drive", 32'h0000_000E, {28'h0, pad_p_oe, pad_p_out, pad_n_oe, pad_n_out});
      axi_rd(lane_pkg::STAT_OFS, lane_pkg::RESP_OKAY);
      chk("stat lp loop", 32'h0000_0005, rd);
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0000, lane_pkg::RESP_OKAY);
      p_drv <= 1'b0;
      n_drv <= 1'b1;
      repeat (4) @(posedge aclk);
      axi_rd(lane_pkg::STAT_OFS, lane_pkg::RESP_OKAY);
      chk("stat lp sense", 32'h0000_0006, rd);
   endtask

   // High-speed serial loopback: order on the pads and the received words.
   task automatic t_loop();
      logic [7:0] s;
      axi_wr(lane_pkg::TXD_OFS, 32'h0000_000B, lane_pkg::RESP_OKAY);
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0007, lane_pkg::RESP_OKAY);
      chk("term on", 32'h1, {31'h0, term_on});
      repeat (20) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         s = {s[6:0], pad_p_out};
         chk("pad n inverse", {31'h0, ~pad_p_out}, {31'h0, pad_n_out});
      end
      chk("tx msb first", 32'h1, {31'h0, is_rot(s, 8'h0B)});
      for (int i = 0; i < 5; i++) axi_rd(lane_pkg::RXD_OFS, lane_pkg::RESP_OKAY);
      repeat (20) @(posedge aclk);
      axi_rd(lane_pkg::RXD_OFS, lane_pkg::RESP_OKAY);
      chk("rx valid", 32'h1, {31'h0, rd[lane_pkg::RXD_VALID]});
      chk("rx byte order", 32'h1, {31'h0, is_rot(rd[7:0], 8'h0B)});
   endtask

   // Receive reset empties the queue; with the buffer off nothing refills it.
   task automatic t_rxreset();
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0087, lane_pkg::RESP_OKAY);
      axi_rd(lane_pkg::RXD_OFS, lane_pkg::RESP_OKAY);
      chk("rxd after reset", 32'h0000_0000, rd);
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0004, lane_pkg::RESP_OKAY);
      repeat (30) @(posedge aclk);
      chk("term off", 32'h0, {31'h0, term_on});
      axi_rd(lane_pkg::STAT_OFS, lane_pkg::RESP_OKAY);
      chk("empty buffer off", 32'h1, {31'h0, rd[lane_pkg::STAT_EMPTY]});
   endtask

   // Serializer held in reset sends nothing even with all-ones data.
   task automatic t_txreset();
      axi_wr(lane_pkg::TXD_OFS, 32'h0000_00FF, lane_pkg::RESP_OKAY);
      axi_wr(lane_pkg::CTRL_OFS, 32'h0000_0104, lane_pkg::RESP_OKAY);
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         chk("tx reset pad", 32'h0, {31'h0, pad_p_out});
      end
   endtask

   // One delay command; the expected tap saturates at both ends and clear wins.
   task automatic t_delay(input logic [2:0] cmd);
      axi_wr(lane_pkg::DLY_OFS, {29'h0, cmd}, lane_pkg::RESP_OKAY);
      repeat (10) @(posedge aclk);
      if (cmd[lane_pkg::DLY_CLR]) exp_tap = lane_pkg::TAP_INIT;
      else if (cmd[lane_pkg::DLY_UP] && exp_tap != lane_pkg::TAP_MAX) exp_tap = exp_tap + 3'h1;
      else if (!cmd[lane_pkg::DLY_UP] && exp_tap != lane_pkg::TAP_MIN) exp_tap = exp_tap - 3'h1;
      axi_rd(lane_pkg::STAT_OFS, lane_pkg::RESP_OKAY);
      chk("delay tap", {29'h0, exp_tap}, {29'h0, rd[6:4]});
   endtask

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      {aresetn, p_drv, n_drv, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      exp_tap = lane_pkg::TAP_INIT;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_lowpwr();
      t_loop();
      t_rxreset();
      t_txreset();
      repeat (9) t_delay(3'h3);
      t_delay(3'h1);
      t_delay(3'h7);
      t_delay(3'h1);
      t_delay(3'h3);
      t_delay(3'h4);
      complete_run();
   end
endmodule
